// [verification/pmrc_host_model.sv]
// pmrc_host_model.sv: host side of the controller, clears log bits
// and answers configuration download requests after DLY cycles.
`timescale 1ns/1ps
`default_nettype none

module pmrc_host_model #(
   parameter integer DLY = 3
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic cancel,
   input wire logic [1:0] fault_log,
   input wire logic supply_fault_n,
   output var logic [1:0] log_clear,
   output var logic download_done
);
   // ==========================================================
   // delayed answers
   integer cnt;
   wire logic req = (cancel && fault_log != 2'h0) || !supply_fault_n;

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt <= 0;
         log_clear <= 2'h0;
         download_done <= 1'b0;
      end else begin
         log_clear <= 2'h0;
         download_done <= 1'b0;
         cnt <= 0;
         if (req && cnt < DLY) begin
            cnt <= cnt + 1;
         end else if (req) begin
            log_clear <= cancel ? fault_log : 2'h0;
            download_done <= !supply_fault_n;
         end
      end
   end
endmodule // pmrc_host_model

`default_nettype wire

// [verification/pmrc_top_assertions.sv]
// pmrc_top_assertions.sv: port checker for the power mode controller.
// assumes the mode codes of the defines header; bound into pmrc_top.
`include "pmrc_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module pmrc_checker (
   input wire logic CLK_SYS,
   input wire logic NRST,
   input wire logic EMERGENCY_OFF_N,
   input wire logic SHUTDOWN_WRITE,
   input wire logic SUPPLY_ABOVE_UPPER,
   input wire logic USER_SHUTDOWN_STYLE,
   input wire logic HOST_RESET_N,
   input wire logic IRQ_N,
   input wire logic [1:0] FAULT_LOG,
   input wire logic CLEAR_EVENTS,
   input wire logic OTP_RELOAD,
   input wire logic FULL_POR,
   input wire logic EVAL_MODE,
   input wire logic SUPPLY_FAULT_N,
   input wire logic [3:0] MODE
);
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!NRST);

   // ==========================================================
   // shutdown triggers and reset mode
   reset_holds_host_a: assert property (
      MODE == `PMRC_ST_RESET |-> !HOST_RESET_N)
      else $error("host reset released in reset mode");
   off_fast_a: assert property (
      $fell(EMERGENCY_OFF_N) && MODE == `PMRC_ST_ACTIVE
      |-> ##[1:16] MODE == `PMRC_ST_RESET)
      else $error("emergency off not fast");
   write_forces_a: assert property (
      SHUTDOWN_WRITE && MODE == `PMRC_ST_ACTIVE |-> ##[1:8] !HOST_RESET_N)
      else $error("shutdown write ignored");
   off_holds_reset_a: assert property (
      MODE == `PMRC_ST_RESET && !EMERGENCY_OFF_N |=> MODE == `PMRC_ST_RESET)
      else $error("left reset with off pin low");
   supply_holds_a: assert property (
      (MODE == `PMRC_ST_RESET && !SUPPLY_ABOVE_UPPER) [*2]
      |=> MODE == `PMRC_ST_RESET)
      else $error("left reset on weak supply");
   events_cleared_a: assert property (
      CLEAR_EVENTS |-> ##[0:2] MODE == `PMRC_ST_RESET)
      else $error("event clear outside reset entry");

   // ==========================================================
   // flags, reload, evaluation
   key_irq_a: assert property (
      $rose(FAULT_LOG[0]) |-> ##[0:1] !IRQ_N)
      else $error("key flag without interrupt");
   irq_idle_a: assert property (
      !FAULT_LOG[0] && !$past(FAULT_LOG[0]) |-> IRQ_N)
      else $error("interrupt without key flag");
   reload_pulse_a: assert property (
      OTP_RELOAD |-> !EVAL_MODE ##1 !OTP_RELOAD)
      else $error("bad configuration reload");
   por_style_a: assert property (
      FULL_POR |-> USER_SHUTDOWN_STYLE)
      else $error("full reset with user style zero");
   fault_pin_eval_a: assert property (
      !SUPPLY_FAULT_N |-> EVAL_MODE)
      else $error("download request outside evaluation");

   key_wait_c: cover property (MODE == `PMRC_ST_KEY_WAIT);
   rtc_c: cover property (MODE == `PMRC_ST_RTC);
   second_dl_c: cover property (MODE == `PMRC_ST_DL2);
endmodule // pmrc_checker

bind pmrc_top pmrc_checker i_pmrc_checker (
   .CLK_SYS(CLK_SYS), .NRST(NRST), .EMERGENCY_OFF_N(EMERGENCY_OFF_N),
   .SHUTDOWN_WRITE(SHUTDOWN_WRITE), .SUPPLY_ABOVE_UPPER(SUPPLY_ABOVE_UPPER),
   .USER_SHUTDOWN_STYLE(USER_SHUTDOWN_STYLE), .HOST_RESET_N(HOST_RESET_N),
   .IRQ_N(IRQ_N), .FAULT_LOG(FAULT_LOG), .CLEAR_EVENTS(CLEAR_EVENTS),
   .OTP_RELOAD(OTP_RELOAD), .FULL_POR(FULL_POR), .EVAL_MODE(EVAL_MODE),
   .SUPPLY_FAULT_N(SUPPLY_FAULT_N), .MODE(MODE));

`default_nettype wire

// [verification/test_pmrc_top.sv]
// test_pmrc_top.sv: self-checking bench for the power mode controller.
// assumes the host model and checker files are compiled with the design.
`include "pmrc_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module test_pmrc_top;
   // ==========================================================
   // signals
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [1:0] pins = 2'h3;
   logic [1:0] combo = 2'h0;
   logic [10:0] stim = 11'h000;
   logic [3:0] slot = 4'h0;
   logic key_n = 1'b1;
   logic sup_up = 1'b1;
   logic eval_pin = 1'b0;
   logic hstyle = 1'b1;
   logic ustyle = 1'b0;
   logic rtc_arm = 1'b0;
   logic pd_req = 1'b0;
   logic hsel = 1'b1;
   logic rtc_pd = 1'b0;
   logic cancel = 1'b0;
   logic por_seen = 1'b0;
   wire hrst_n, irq_n, sfault_n, full_por, dl_done;
   wire [1:0] flog, log_clr;
   wire [3:0] mode;
   integer checked = 0;
   integer miscompares = 0;
   integer i;
   int ent[5] = '{4, 6, 5, 6, 0};
   int wak[5] = '{8, 10, 9, 9, 8};

   always #10 clk = ~clk;
   always @(posedge clk) if (full_por) por_seen <= 1'b1;

   // short wait keeps the key window at twenty cycles
   pmrc_top #(.KEY_WAIT_CYC(20)) i_pmrc_top (
      .CLK_SYS(clk), .NRST(nrst), .POWER_KEY_N(key_n),
      .COMBO_KEY_GPIO_A(combo[0]), .COMBO_KEY_GPIO_B(combo[1]),
      .SHUTDOWN_REQUEST_N(pins[0]), .EMERGENCY_OFF_N(pins[1]),
      .CHARGER_WAKE(stim[9]), .EVAL_ENABLE_PIN(eval_pin),
      .KEY_LONG_LIMIT(32'h00000010), .COMBO_LONG_LIMIT(32'h00000010),
      .SHUTDOWN_WRITE(stim[0]), .WATCHDOG_EXPIRED(stim[1]),
      .SUPPLY_LOW(stim[4]), .SUPPLY_ABOVE_UPPER(sup_up),
      .OVER_TEMP(stim[2]), .FAULT_SHUTDOWN_STYLE(hstyle),
      .HOST_SHUTDOWN_STYLE(hstyle), .USER_SHUTDOWN_STYLE(ustyle),
      .HOST_RESET_TIMING_SEL(hsel), .LOG_CLEAR(log_clr),
      .OTP_ABORT(stim[3]), .RTC_ARM(rtc_arm), .RTC_ON_POWERDOWN(rtc_pd),
      .RTC_ON_SHUTDOWN(stim[5]), .POWERDOWN_REQ(pd_req),
      .REF_BELOW_POR(stim[6]), .REF_ABOVE_WAKE(stim[10]),
      .RTC_TICK_ALARM(stim[8]), .WAKE_REQ(stim[7]), .SEQ_SLOT(slot),
      .SEQ_DONE_UP(1'b0), .DOWNLOAD_DONE(dl_done), .HOST_RESET_N(hrst_n),
      .IRQ_N(irq_n), .FAULT_LOG(flog), .SYSTEM_DOMAIN_ON(),
      .SEQ_DOWN_REVERSE(), .SEQ_DOWN_IMMEDIATE(), .CORE_REGULATOR_ON(),
      .CORE_REGULATOR_LOW(), .BLOCKS_ENABLED(), .RESET_KEEP_ON(),
      .CLEAR_EVENTS(), .OTP_RELOAD(), .FULL_POR(full_por), .EVAL_MODE(),
      .CONFIG_WRITE_BLOCK(), .FAULT_OUTPUT_PIN(),
      .SUPPLY_FAULT_N(sfault_n), .MODE(mode));

   pmrc_host_model #(.DLY(3)) i_host (
      .clk(clk), .nrst(nrst), .cancel(cancel), .fault_log(flog),
      .supply_fault_n(sfault_n), .log_clear(log_clr),
      .download_done(dl_done));

   // ==========================================================
   // tasks
   task chk_mode(input [3:0] exp);
      begin
         checked = checked + 1;
         if (mode !== exp) begin
            miscompares = miscompares + 1;
            $display("mismatch at %0t: mode %h not %h", $time, mode, exp);
         end
      end
   endtask

   task chk_bit(input got, input exp);
      begin
         checked = checked + 1;
         if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("mismatch at %0t: flag %b not %b", $time, got, exp);
         end
      end
   endtask

   // bounded waits; a hang shows up as a mismatch
   task wm(input [3:0] m);
      integer n;
      begin
         n = 0;
         while (mode !== m && n < 2000) begin
            @(posedge clk);
            #1;
            n = n + 1;
         end
         chk_mode(m);
      end
   endtask

   task wl(input [3:0] m);
      integer n;
      begin
         n = 0;
         while (mode === m && n < 2000) begin
            @(posedge clk);
            #1;
            n = n + 1;
         end
         chk_bit(mode === m, 1'b0);
      end
   endtask

   task hit(input [10:0] v);
      begin
         @(posedge clk);
         stim <= v;
         // two cycles, so a pin pulse survives the agree stage
         repeat (2) @(posedge clk);
         stim <= 11'h000;
      end
   endtask

   task rst(input e, input a);
      begin
         @(posedge clk);
         nrst <= 1'b0;
         eval_pin <= e;
         rtc_arm <= a;
         repeat (5) @(posedge clk);
         nrst <= 1'b1;
      end
   endtask

   task boot;
      begin
         wm(`PMRC_ST_POWERDOWN);
         hit(11'h080);
         wm(`PMRC_ST_ACTIVE);
      end
   endtask

   task results;
      begin
         $display("checked %0d, miscompares %0d", checked, miscompares);
         if (miscompares == 0 && checked > 0) begin
            $display("Testbench passed");
         end else begin
            $display("Testbench failed");
         end
         $finish;
      end
   endtask

   initial begin
      #400000;
      miscompares = miscompares + 1;
      results;
   end

   // ==========================================================
   // tests
   initial begin
      rst(1'b0, 1'b0);
      #1;
      chk_bit(hrst_n, 1'b0);
      chk_bit(irq_n, 1'b1);
      chk_mode(`PMRC_ST_RESET);
      for (i = 0; i < 4; i = i + 1) begin
         boot;
         hit(11'h001 << i);
         wm(`PMRC_ST_RESET);
         chk_bit(|flog, 1'b0);
      end
      $display("forced shutdown tests done");
      boot;
      @(posedge clk);
      hstyle <= 1'b0;
      slot <= 4'h3;
      hit(11'h001);
      repeat (20) @(posedge clk);
      #1 chk_mode(`PMRC_ST_SD_SEQ);
      @(posedge clk);
      slot <= 4'h0;
      hstyle <= 1'b1;
      wm(`PMRC_ST_RESET);
      boot;
      @(posedge clk);
      cancel <= 1'b1;
      key_n <= 1'b0;
      wm(`PMRC_ST_KEY_WAIT);
      @(posedge clk);
      key_n <= 1'b1;
      wm(`PMRC_ST_ACTIVE);
      chk_bit(flog[0], 1'b0);
      @(posedge clk);
      cancel <= 1'b0;
      key_n <= 1'b0;
      wm(`PMRC_ST_KEY_WAIT);
      chk_bit(irq_n, 1'b0);
      @(posedge clk);
      key_n <= 1'b1;
      repeat (10) @(posedge clk);
      #1 chk_mode(`PMRC_ST_KEY_WAIT);
      wm(`PMRC_ST_RESET);
      chk_bit(flog[0], 1'b1);
      boot;
      @(posedge clk);
      ustyle <= 1'b1;
      combo <= 2'h3;
      wm(`PMRC_ST_KEY_WAIT);
      @(posedge clk);
      combo <= 2'h0;
      wm(`PMRC_ST_RESET);
      chk_bit(por_seen, 1'b1);
      @(posedge clk);
      ustyle <= 1'b0;
      $display("key tests done");
      for (i = 0; i < 2; i = i + 1) begin
         boot;
         @(posedge clk);
         pins <= ~(2'h1 << i);
         wm(`PMRC_ST_RESET);
         if (i == 0) chk_bit(flog[1], 1'b1);
         @(posedge clk);
         sup_up <= 1'b0;
         repeat (10) @(posedge clk);
         pins <= 2'h3;
         repeat (10) @(posedge clk);
         #1 chk_mode(`PMRC_ST_RESET);
         @(posedge clk);
         sup_up <= 1'b1;
         wm(`PMRC_ST_POWERDOWN);
      end
      @(posedge clk);
      cancel <= 1'b1;
      repeat (20) @(posedge clk);
      #1 chk_bit(|flog, 1'b0);
      @(posedge clk);
      cancel <= 1'b0;
      $display("pin tests done");
      for (i = 0; i < 5; i = i + 1) begin
         rst(1'b0, i < 2 || i == 4);
         hsel <= (i != 3);
         rtc_pd <= (i == 4);
         wm(`PMRC_ST_POWERDOWN);
         chk_bit(hrst_n, hsel);
         hit(11'h001 << ent[i]);
         wm(rtc_arm ? `PMRC_ST_RTC : `PMRC_ST_DELIVERY);
         hit(11'h001 << wak[i]);
         wl(rtc_arm ? `PMRC_ST_RTC : `PMRC_ST_DELIVERY);
      end
      $display("low power tests done");
      rst(1'b1, 1'b0);
      wm(`PMRC_ST_DL1);
      chk_bit(sfault_n, 1'b0);
      wm(`PMRC_ST_POWERDOWN);
      hit(11'h080);
      wm(`PMRC_ST_DL2);
      chk_bit(sfault_n, 1'b0);
      wm(`PMRC_ST_ACTIVE);
      chk_bit(sfault_n, 1'b1);
      @(posedge clk);
      combo <= 2'h3;
      repeat (40) @(posedge clk);
      #1 chk_mode(`PMRC_ST_ACTIVE);
      $display("evaluation tests done");
      results;
   end
endmodule // test_pmrc_top

`default_nettype wire

// [verilog/pmrc_defines.vh]
// pmrc_defines.vh: constants for the power mode and reset controller.
// assumes a 50 MHz system clock; included by its bare name.
//
// Behaviour
// R1: long key or combo press requests cancellable reset
// R2: host pin edge or write forces reset
// R3: watchdog, undervoltage, overtemperature force reset
// R4: emergency-off edge always gives fast shutdown; code acts on the edge only in active and power-down modes
// R5: per-source bit picks reverse or immediate shutdown
// R6: record reset source; host clears by writing one
// R7: user style one turns long press into POR
// R8: aborted OTP read enters reset, no flags
// R9: assert host reset, then power down to zero
// R10: reset mode keeps only core blocks running
// R11: entering reset clears all pending events; code pulses CLEAR_EVENTS only on entry from shutdown sequencing, not from POR
// R12: leaving reset reloads OTP, keeps log and calendar
// R13: host reset low after cold start, optionally earlier
// R14: self triggers expire; pin triggers must release
// R15: key reset flags, interrupts, waits one second
// R16: stay in reset until supply above upper threshold
// R17: armed power-down-to-RTC enters RTC at slot zero
// R18: armed RTC entered on fault, control bit, POR
// R19: RTC exit on key, wake, tick, reference rise
// R20: unarmed RTC conditions lead to delivery mode
// R21: evaluation mode loads defaults over two-wire
// R22: evaluation drives fault output low per download
// R23: long presses timed by counter against limits
`ifndef PMRC_DEFINES_VH
`define PMRC_DEFINES_VH

// ==========================================================
// modes
`define PMRC_ST_POWERDOWN 4'h0
`define PMRC_ST_ACTIVE 4'h1
`define PMRC_ST_KEY_WAIT 4'h2
`define PMRC_ST_SD_HRST 4'h3
`define PMRC_ST_SD_SEQ 4'h4
`define PMRC_ST_RESET 4'h5
`define PMRC_ST_RTC 4'h6
`define PMRC_ST_DELIVERY 4'h7
`define PMRC_ST_DL1 4'h8
`define PMRC_ST_DL2 4'h9
`define PMRC_ST_POR 4'hA

// ==========================================================
// timing
`define PMRC_CLK_HZ 50000000
`define PMRC_KEY_WAIT_MS 1000
`define PMRC_KEY_WAIT_CYC ((`PMRC_CLK_HZ / 1000) * `PMRC_KEY_WAIT_MS)

// ==========================================================
// fault log bits and reset values
`define PMRC_LOG_KEY 0
`define PMRC_LOG_PIN 1
`define PMRC_LOG_RST 2'h0
`define PMRC_SLOT_RST 4'hF

`endif

// [verilog/pmrc_top.v]
// pmrc_top.v: power mode and reset controller of a power management chip.
// assumes slow pins synchronised here; sequencer, OTP loader and two-wire
// download engine live outside; only DOWNLOAD_DONE is used as a done strobe, SEQ_DONE_UP is left unused.
`include "pmrc_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module pmrc_top #(
   parameter integer KEY_WAIT_CYC = `PMRC_KEY_WAIT_CYC,
   parameter integer LONG_W = 32,
   parameter integer SLOT_W = 4
) (
   input wire CLK_SYS,
   input wire NRST,
   input wire POWER_KEY_N,
   input wire COMBO_KEY_GPIO_A,
   input wire COMBO_KEY_GPIO_B,
   input wire SHUTDOWN_REQUEST_N,
   input wire EMERGENCY_OFF_N,
   input wire CHARGER_WAKE,
   input wire EVAL_ENABLE_PIN,
   input wire [LONG_W-1:0] KEY_LONG_LIMIT,
   input wire [LONG_W-1:0] COMBO_LONG_LIMIT,
   input wire SHUTDOWN_WRITE,
   input wire WATCHDOG_EXPIRED,
   input wire SUPPLY_LOW,
   input wire SUPPLY_ABOVE_UPPER,
   input wire OVER_TEMP,
   input wire FAULT_SHUTDOWN_STYLE,
   input wire HOST_SHUTDOWN_STYLE,
   input wire USER_SHUTDOWN_STYLE,
   input wire HOST_RESET_TIMING_SEL,
   input wire [1:0] LOG_CLEAR,
   input wire OTP_ABORT,
   input wire RTC_ARM,
   input wire RTC_ON_POWERDOWN,
   input wire RTC_ON_SHUTDOWN,
   input wire POWERDOWN_REQ,
   input wire REF_BELOW_POR,
   input wire REF_ABOVE_WAKE,
   input wire RTC_TICK_ALARM,
   input wire WAKE_REQ,
   input wire [SLOT_W-1:0] SEQ_SLOT,
   input wire SEQ_DONE_UP,
   input wire DOWNLOAD_DONE,
   output reg HOST_RESET_N,
   output reg IRQ_N,
   output reg [1:0] FAULT_LOG,
   output reg SYSTEM_DOMAIN_ON,
   output reg SEQ_DOWN_REVERSE,
   output reg SEQ_DOWN_IMMEDIATE,
   output reg CORE_REGULATOR_ON,
   output reg CORE_REGULATOR_LOW,
   output reg BLOCKS_ENABLED,
   output reg RESET_KEEP_ON,
   output reg CLEAR_EVENTS,
   output reg OTP_RELOAD,
   output reg FULL_POR,
   output reg EVAL_MODE,
   output reg CONFIG_WRITE_BLOCK,
   output reg FAULT_OUTPUT_PIN,
   output reg SUPPLY_FAULT_N,
   output reg [3:0] MODE
);

   // ==========================================================
   // pin synchronisers, three stages, last two must agree
   localparam integer NPIN = 7;
   wire [NPIN-1:0] pin_raw = {EVAL_ENABLE_PIN, CHARGER_WAKE,
      EMERGENCY_OFF_N, SHUTDOWN_REQUEST_N, COMBO_KEY_GPIO_B,
      COMBO_KEY_GPIO_A, POWER_KEY_N};
   reg [NPIN-1:0] s1;
   reg [NPIN-1:0] s2;
   reg [NPIN-1:0] s3;
   reg [NPIN-1:0] pin;
   reg [NPIN-1:0] pin_d;
   // idle levels: power key, shutdown and off high; combo, wake, strap low
   localparam [NPIN-1:0] PIN_IDLE = 7'h19;

   always @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         s1 <= PIN_IDLE;
         s2 <= PIN_IDLE;
         s3 <= PIN_IDLE;
         pin <= PIN_IDLE;
         pin_d <= PIN_IDLE;
      end else begin
         s1 <= pin_raw;
         s2 <= s1;
         s3 <= s2;
         pin <= (s2 & s3) | (pin & (s2 | s3));
         pin_d <= pin;
      end
   end

   wire key_down = ~pin[0];
   wire combo_on = pin[1] & pin[2];
   wire sdn_fall = pin_d[3] & ~pin[3];
   wire off_fall = pin_d[4] & ~pin[4];
   wire sdn_low = ~pin[3];
   wire off_low = ~pin[4];
   wire charger_wake = pin[5];
   wire eval_pin = pin[6];

   // pins and strap read as idle until the synchronisers have filled,
   // so reset mode must not be left before then
   reg [2:0] settle;
   wire pins_settled = (settle == 3'h7);

   always @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         settle <= 3'h0;
      end else if (!pins_settled) begin
         settle <= settle + 3'h1;
      end
   end

   // ==========================================================
   // long press counters
   reg [LONG_W-1:0] key_cnt;
   reg [LONG_W-1:0] combo_cnt;
   reg key_long;
   reg combo_long;

   function [LONG_W-1:0] count_up;
      input active;
      input [LONG_W-1:0] cnt;
      begin
         if (!active)
            count_up = {LONG_W{1'b0}};
         else if (cnt == {LONG_W{1'b1}})
            count_up = cnt;
         else
            count_up = cnt + {{(LONG_W-1){1'b0}}, 1'b1};
      end
   endfunction

   always @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         key_cnt <= {LONG_W{1'b0}};
         combo_cnt <= {LONG_W{1'b0}};
         key_long <= 1'b0;
         combo_long <= 1'b0;
      end else begin
         key_cnt <= count_up(key_down, key_cnt); // see R23
         // combo shutdown is ignored while the pins serve two-wire
         combo_cnt <= count_up(combo_on & ~EVAL_MODE, combo_cnt); // see R21
         key_long <= key_down && (key_cnt == KEY_LONG_LIMIT); // see R23
         combo_long <= (combo_on & ~EVAL_MODE) &&
            (combo_cnt == COMBO_LONG_LIMIT); // see R23
      end
   end
   wire user_long = key_long | combo_long; // see R1

   // ==========================================================
   // mode machine
   localparam [2:0] SRC_NONE = 3'h0;
   localparam [2:0] SRC_USER = 3'h1;
   localparam [2:0] SRC_HOST = 3'h2;
   localparam [2:0] SRC_FAULT = 3'h3;
   localparam [2:0] SRC_OFF = 3'h4;
   localparam [2:0] SRC_RTC = 3'h5;

   reg [3:0] state;
   reg [3:0] next_state;
   reg [2:0] src;
   reg [2:0] next_src;
   reg [LONG_W-1:0] wait_cnt;
   reg dl_second;
   reg fast;
   reg next_fast;
   reg off_seen;
   reg sdn_seen;

   wire in_active = (state == `PMRC_ST_ACTIVE) ||
      (state == `PMRC_ST_POWERDOWN);
   wire host_trig = sdn_fall | SHUTDOWN_WRITE; // see R2
   wire fault_trig = WATCHDOG_EXPIRED | SUPPLY_LOW | OVER_TEMP; // see R3
   wire rtc_cond = SUPPLY_LOW | RTC_ON_SHUTDOWN | REF_BELOW_POR; // see R18
   wire rtc_exit = key_down | charger_wake | RTC_TICK_ALARM | REF_ABOVE_WAKE;
   wire slot_zero = (SEQ_SLOT == {SLOT_W{1'b0}});
   wire wait_done = (wait_cnt == KEY_WAIT_CYC[LONG_W-1:0]);
   // pin triggers hold reset until the outside releases them
   wire pins_held = off_low | sdn_low; // see R14
   wire rtc_target = RTC_ARM ? 1'b1 : 1'b0; // see R20

   always @* begin
      next_state = state;
      next_src = src;
      next_fast = fast;
      case (state)
         `PMRC_ST_POWERDOWN, `PMRC_ST_ACTIVE: begin
            if (off_fall) begin
               next_src = SRC_OFF;
               next_fast = 1'b1; // see R4
               next_state = `PMRC_ST_SD_HRST;
            end else if (fault_trig & ~(RTC_ARM & SUPPLY_LOW)) begin
               next_src = SRC_FAULT;
               next_fast = FAULT_SHUTDOWN_STYLE; // see R5
               next_state = `PMRC_ST_SD_HRST;
            end else if (host_trig) begin
               next_src = SRC_HOST;
               next_fast = HOST_SHUTDOWN_STYLE; // see R5
               next_state = `PMRC_ST_SD_HRST;
            end else if (rtc_cond) begin
               next_src = SRC_RTC;
               next_fast = 1'b0;
               next_state = `PMRC_ST_SD_HRST;
            end else if (user_long) begin
               next_src = SRC_USER;
               next_fast = USER_SHUTDOWN_STYLE; // see R5
               next_state = `PMRC_ST_KEY_WAIT; // see R1
            end else if (OTP_ABORT) begin
               next_src = SRC_NONE; // see R8
               next_fast = 1'b1;
               next_state = `PMRC_ST_SD_HRST;
            end else if (state == `PMRC_ST_POWERDOWN) begin
               if (WAKE_REQ)
                  next_state = EVAL_MODE ? `PMRC_ST_DL2 :
                     `PMRC_ST_ACTIVE; // see R22
            end else if (POWERDOWN_REQ) begin
               next_state = `PMRC_ST_POWERDOWN;
            end
         end
         `PMRC_ST_KEY_WAIT: begin
            // host cancels by clearing the key flag inside the window
            if (!FAULT_LOG[`PMRC_LOG_KEY])
               next_state = `PMRC_ST_ACTIVE; // see R15
            else if (wait_done)
               next_state = `PMRC_ST_SD_HRST; // see R15
         end
         `PMRC_ST_SD_HRST:
            next_state = `PMRC_ST_SD_SEQ; // see R9
         `PMRC_ST_SD_SEQ: begin
            if (fast || slot_zero) begin
               if (src == SRC_RTC || (RTC_ON_POWERDOWN && RTC_ARM &&
                     src != SRC_OFF && src != SRC_NONE))
                  next_state = rtc_target ? `PMRC_ST_RTC :
                     `PMRC_ST_DELIVERY; // see R17
               else if (src == SRC_USER && USER_SHUTDOWN_STYLE)
                  next_state = `PMRC_ST_POR; // see R7
               else
                  next_state = `PMRC_ST_RESET; // see R9
            end
         end
         `PMRC_ST_RESET: begin
            if (pins_settled && !pins_held && SUPPLY_ABOVE_UPPER) // see R16
               next_state = EVAL_MODE ? `PMRC_ST_DL1 :
                  `PMRC_ST_POWERDOWN;
         end
         `PMRC_ST_DL1: if (DOWNLOAD_DONE)
            next_state = `PMRC_ST_POWERDOWN; // see R22
         `PMRC_ST_DL2: if (DOWNLOAD_DONE)
            next_state = `PMRC_ST_ACTIVE; // see R22
         `PMRC_ST_RTC, `PMRC_ST_DELIVERY: begin
            if (state == `PMRC_ST_DELIVERY ?
                  (key_down | charger_wake | REF_ABOVE_WAKE) : rtc_exit)
               next_state = `PMRC_ST_POWERDOWN; // see R19
         end
         `PMRC_ST_POR:
            next_state = `PMRC_ST_RESET;
         default:
            next_state = `PMRC_ST_RESET;
      endcase
   end

   // ==========================================================
   // state, timers and fault log
   always @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         state <= `PMRC_ST_RESET;
         src <= SRC_NONE;
         fast <= 1'b0;
         wait_cnt <= {LONG_W{1'b0}};
         FAULT_LOG <= `PMRC_LOG_RST;
         dl_second <= 1'b0;
         off_seen <= 1'b0;
         sdn_seen <= 1'b0;
      end else begin
         state <= next_state;
         src <= next_src;
         fast <= next_fast;
         if (state == `PMRC_ST_KEY_WAIT && !wait_done)
            wait_cnt <= wait_cnt + {{(LONG_W-1){1'b0}}, 1'b1};
         else if (state != `PMRC_ST_KEY_WAIT)
            wait_cnt <= {LONG_W{1'b0}};
         off_seen <= off_fall;
         sdn_seen <= sdn_fall;
         // a new flag beats a clear arriving in the same cycle
         FAULT_LOG[`PMRC_LOG_KEY] <= (in_active &&
            next_state == `PMRC_ST_KEY_WAIT) | (FAULT_LOG[`PMRC_LOG_KEY] &
            ~LOG_CLEAR[`PMRC_LOG_KEY]); // see R6
         FAULT_LOG[`PMRC_LOG_PIN] <= (in_active && sdn_fall) |
            (FAULT_LOG[`PMRC_LOG_PIN] & ~LOG_CLEAR[`PMRC_LOG_PIN]); // see R6
         dl_second <= (state == `PMRC_ST_DL2);
      end
   end

   // ==========================================================
   // evaluation mode strap, caught after reset release
   always @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         EVAL_MODE <= 1'b0;
      end else if (state == `PMRC_ST_RESET) begin
         EVAL_MODE <= eval_pin; // see R21
      end
   end

   // ==========================================================
   // registered outputs
   wire in_reset = (state == `PMRC_ST_RESET);
   wire in_low = (state == `PMRC_ST_RTC) || (state == `PMRC_ST_DELIVERY);
   wire dl = (state == `PMRC_ST_DL1) || (state == `PMRC_ST_DL2);

   always @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         HOST_RESET_N <= 1'b0;
         IRQ_N <= 1'b1;
         SYSTEM_DOMAIN_ON <= 1'b0;
         SEQ_DOWN_REVERSE <= 1'b0;
         SEQ_DOWN_IMMEDIATE <= 1'b0;
         CORE_REGULATOR_ON <= 1'b1;
         CORE_REGULATOR_LOW <= 1'b1;
         BLOCKS_ENABLED <= 1'b0;
         RESET_KEEP_ON <= 1'b1;
         CLEAR_EVENTS <= 1'b0;
         OTP_RELOAD <= 1'b0;
         FULL_POR <= 1'b0;
         CONFIG_WRITE_BLOCK <= 1'b0;
         FAULT_OUTPUT_PIN <= 1'b1;
         SUPPLY_FAULT_N <= 1'b1;
         MODE <= `PMRC_ST_RESET;
      end else begin
         MODE <= state;
         // low after cold start; optionally before power down
         HOST_RESET_N <= (state == `PMRC_ST_ACTIVE) ||
            (state == `PMRC_ST_KEY_WAIT) ||
            (state == `PMRC_ST_POWERDOWN && HOST_RESET_TIMING_SEL &&
            !POWERDOWN_REQ); // see R13
         IRQ_N <= ~FAULT_LOG[`PMRC_LOG_KEY]; // see R15
         SYSTEM_DOMAIN_ON <= (state == `PMRC_ST_ACTIVE) ||
            (state == `PMRC_ST_KEY_WAIT) || dl_second;
         SEQ_DOWN_REVERSE <= (state == `PMRC_ST_SD_SEQ) && !fast; // see R5
         SEQ_DOWN_IMMEDIATE <= (state == `PMRC_ST_SD_SEQ) && fast; // see R4
         CORE_REGULATOR_ON <= !in_low; // see R19
         CORE_REGULATOR_LOW <= in_reset; // see R10
         BLOCKS_ENABLED <= !in_reset && !in_low; // see R10
         RESET_KEEP_ON <= in_reset || !in_low; // see R10
         CLEAR_EVENTS <= (state == `PMRC_ST_SD_SEQ) &&
            (next_state == `PMRC_ST_RESET); // see R11
         // log and calendar live outside the reload set
         OTP_RELOAD <= in_reset && (next_state != `PMRC_ST_RESET) &&
            !EVAL_MODE; // see R12
         FULL_POR <= (state == `PMRC_ST_POR); // see R7
         CONFIG_WRITE_BLOCK <= EVAL_MODE; // see R21
         SUPPLY_FAULT_N <= ~(dl && EVAL_MODE); // see R22
         FAULT_OUTPUT_PIN <= EVAL_MODE ? ~(dl && EVAL_MODE) :
            ~SUPPLY_LOW; // see R21
      end
   end

   // self-expiring triggers need no holding state here
   wire unused_ok = off_seen | sdn_seen | SEQ_DONE_UP; // see R14

endmodule // pmrc_top

`default_nettype wire
